/* File: include/bst_pkg.sv */
// Shared constants and types for the boundary-scan test port
package bst_pkg;

  localparam int IR_W = 5;
  localparam int ID_W = 32;
  localparam int NUM_PINS = 8;
  localparam int BS_W = 2 * NUM_PINS;
  localparam int SHARED_W = 4;

  // Instruction codes
  localparam logic [IR_W-1:0] IR_EXTEST   = 5'h00;
  localparam logic [IR_W-1:0] IR_IDCODE   = 5'h01;
  localparam logic [IR_W-1:0] IR_SAMPLE   = 5'h02;
  localparam logic [IR_W-1:0] IR_INTEST   = 5'h03;
  localparam logic [IR_W-1:0] IR_HIGHZ    = 5'h05;
  localparam logic [IR_W-1:0] IR_BYPASS   = 5'h1F;

  // Fixed pattern loaded into the instruction shifter on capture
  localparam logic [IR_W-1:0] IR_CAPTURE  = 5'h01;
  localparam logic [IR_W-1:0] IR_RESET    = IR_IDCODE;

  // Identification value is arbitrary; bit 0 must stay set
  localparam logic [ID_W-1:0] ID_VALUE    = 32'h0A5A_5001;

  // Boundary cell layout: data cell of pin i at 2i, enable cell at 2i+1
  localparam int BS_DATA_OFS = 0;
  localparam int BS_EN_OFS   = 1;

  // Shared pin positions
  localparam int SH_TCK = 0;
  localparam int SH_TMS = 1;
  localparam int SH_TDI = 2;
  localparam int SH_TDO = 3;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE,
    TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
    TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } bst_tap_e;

endpackage

/* File: design/bst_sync3.sv */
// Three-stage input synchroniser that accepts a bit once stages two and three agree
module bst_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Bits still in disagreement keep their last accepted value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= (s3 & ~(s2 ^ s3)) | (q & (s2 ^ s3));
    end
  end

endmodule

/* File: design/bst_tap_fsm.sv */
// Test access port controller state machine
module bst_tap_fsm (
  input  wire logic      tck,
  input  wire logic      rst_n,
  input  wire logic      hold,
  input  wire logic      tms,
  output bst_pkg::bst_tap_e state
);

  bst_pkg::bst_tap_e next_state;

  always_comb begin
    next_state = state;
    case (state)
      bst_pkg::TAP_RESET:    next_state = tms ? bst_pkg::TAP_RESET : bst_pkg::TAP_IDLE;
      bst_pkg::TAP_IDLE:     next_state = tms ? bst_pkg::TAP_SEL_DR : bst_pkg::TAP_IDLE;
      bst_pkg::TAP_SEL_DR:   next_state = tms ? bst_pkg::TAP_SEL_IR : bst_pkg::TAP_CAP_DR;
      bst_pkg::TAP_CAP_DR:   next_state = tms ? bst_pkg::TAP_EXIT1_DR : bst_pkg::TAP_SHIFT_DR;
      bst_pkg::TAP_SHIFT_DR: next_state = tms ? bst_pkg::TAP_EXIT1_DR : bst_pkg::TAP_SHIFT_DR;
      bst_pkg::TAP_EXIT1_DR: next_state = tms ? bst_pkg::TAP_UPD_DR : bst_pkg::TAP_PAUSE_DR;
      bst_pkg::TAP_PAUSE_DR: next_state = tms ? bst_pkg::TAP_EXIT2_DR : bst_pkg::TAP_PAUSE_DR;
      bst_pkg::TAP_EXIT2_DR: next_state = tms ? bst_pkg::TAP_UPD_DR : bst_pkg::TAP_SHIFT_DR;
      bst_pkg::TAP_UPD_DR:   next_state = tms ? bst_pkg::TAP_SEL_DR : bst_pkg::TAP_IDLE;
      bst_pkg::TAP_SEL_IR:   next_state = tms ? bst_pkg::TAP_RESET : bst_pkg::TAP_CAP_IR;
      bst_pkg::TAP_CAP_IR:   next_state = tms ? bst_pkg::TAP_EXIT1_IR : bst_pkg::TAP_SHIFT_IR;
      bst_pkg::TAP_SHIFT_IR: next_state = tms ? bst_pkg::TAP_EXIT1_IR : bst_pkg::TAP_SHIFT_IR;
      bst_pkg::TAP_EXIT1_IR: next_state = tms ? bst_pkg::TAP_UPD_IR : bst_pkg::TAP_PAUSE_IR;
      bst_pkg::TAP_PAUSE_IR: next_state = tms ? bst_pkg::TAP_EXIT2_IR : bst_pkg::TAP_PAUSE_IR;
      bst_pkg::TAP_EXIT2_IR: next_state = tms ? bst_pkg::TAP_UPD_IR : bst_pkg::TAP_SHIFT_IR;
      bst_pkg::TAP_UPD_IR:   next_state = tms ? bst_pkg::TAP_SEL_DR : bst_pkg::TAP_IDLE;
      default:               next_state = bst_pkg::TAP_RESET;
    endcase
  end

  // Held in reset while the shared pins serve as user I/O
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      state <= bst_pkg::TAP_RESET;
    end else if (hold) begin
      state <= bst_pkg::TAP_RESET; // R06
    end else begin
      state <= next_state; // R19
    end
  end

endmodule

/* File: design/bst_test_port.sv */
// Boundary-scan test access port with shared-pin reclaim and pin muxing
// Function
// R01 - No test-reset pin; power-up reset initialises all test logic.
// R02 - Reclaim pin high returns the four shared pins to test use.
// R03 - Reclaim pin low again gives configured pins back to user I/O.
// R04 - System keeps reclaim pin low during power-up.
// R05 - Unconfigured device uses the shared pins as the test port.
// R06 - Shared pins as user I/O with reclaim low ignore test signalling.
// R07 - In test mode, shared-pin macrocells work internally but never drive pins.
// R08 - Code 00010 samples pin states and preloads boundary update latches.
// R09 - Code 00000 drives pins from boundary update latches.
// R10 - Code 11111 puts one-bit bypass between data in and out.
// R11 - Shifting all ones through instruction scan yields bypass.
// R12 - Code 00001 shifts the identification value out.
// R13 - Code 00101 floats all system outputs and selects bypass.
// R14 - Code 00011 applies boundary register values to the core logic.
// R15 - Serial inputs sampled on rising test clock edge.
// R16 - Serial output changes on falling test clock edge.
// R17 - Serial output floats unless shifting instruction or data.
// R18 - Controller keeps mode select high during normal user operation.
// R19 - Five-bit instruction register and standard controller state machine.
// R20 - Unknown instruction codes select bypass.
module bst_test_port (
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  input  wire logic                          tck,
  input  wire logic                          tms,
  input  wire logic                          tdi,
  output logic                               tdo,
  output logic                               tdo_oe,
  input  wire logic                          port_reclaim,
  input  wire logic                          cfg_pins_user_io,
  input  wire logic [bst_pkg::SHARED_W-1:0]  shared_pad_in,
  output logic      [bst_pkg::SHARED_W-1:0]  shared_pad_out,
  output logic      [bst_pkg::SHARED_W-1:0]  shared_pad_oe,
  input  wire logic [bst_pkg::SHARED_W-1:0]  user_out,
  input  wire logic [bst_pkg::SHARED_W-1:0]  user_oe,
  output logic      [bst_pkg::SHARED_W-1:0]  user_in,
  input  wire logic [bst_pkg::NUM_PINS-1:0]  pin_in,
  output logic      [bst_pkg::NUM_PINS-1:0]  pin_out,
  output logic      [bst_pkg::NUM_PINS-1:0]  pin_oe,
  input  wire logic [bst_pkg::NUM_PINS-1:0]  core_out,
  input  wire logic [bst_pkg::NUM_PINS-1:0]  core_oe,
  output logic      [bst_pkg::NUM_PINS-1:0]  core_in
);

  localparam int IW = bst_pkg::IR_W;
  localparam int NP = bst_pkg::NUM_PINS;
  localparam int BW = bst_pkg::BS_W;
  localparam int SW = bst_pkg::SHARED_W;

  // Instruction decode used only by the test clock domain
  function automatic logic is_bs_reg(input logic [IW-1:0] code);
    is_bs_reg = (code == bst_pkg::IR_EXTEST) || (code == bst_pkg::IR_SAMPLE) ||
                (code == bst_pkg::IR_INTEST);
  endfunction

  // Gather the data or enable cells of the boundary vector
  function automatic logic [NP-1:0] bs_cells(input logic [BW-1:0] v, input int ofs);
    logic [NP-1:0] r;
    r = '0;
    for (int i = 0; i < NP; i++) begin
      r[i] = v[2*i+ofs];
    end
    bs_cells = r;
  endfunction

  // Test clock side registers, declared ahead of their first use
  logic                rst_tck_src;
  logic                rst_tck_q1;
  logic                rst_tck_n;
  logic                active_tck;
  logic [BW-1:0]       snap_tck;
  bst_pkg::bst_tap_e   state;
  logic [IW-1:0]       ir_sr;
  logic [IW-1:0]       ir;
  logic                bypass_sr;
  logic [bst_pkg::ID_W-1:0] id_sr;
  logic [BW-1:0]       bs_sr;
  logic [BW-1:0]       bs_upd;
  logic                upd_tog;
  logic                dr_bit;

  // ---------------- System domain ----------------
  logic          rst_sys_q1;
  logic          rst_sys_n;
  logic          reclaim_s;
  logic [SW-1:0] shared_in_s;
  logic [NP-1:0] pin_in_s;
  logic          cfg_user_io;
  logic          test_active;
  logic          upd_tog_s;
  logic          upd_tog_seen;
  logic [IW-1:0] ir_sys;
  logic [BW-1:0] bs_sys;
  logic [BW-1:0] snap_sys;

  // Power-up reset stands in for a test reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_sys_q1 <= 1'b0; // R01
      rst_sys_n  <= 1'b0;
    end else begin
      rst_sys_q1 <= 1'b1;
      rst_sys_n  <= rst_sys_q1;
    end
  end

  bst_sync3 #(.W(1)) u_sync_reclaim (
    .clk   (clk_sys),
    .rst_n (rst_sys_n),
    .d     (port_reclaim),
    .q     (reclaim_s)
  );

  bst_sync3 #(.W(SW)) u_sync_shared (
    .clk   (clk_sys),
    .rst_n (rst_sys_n),
    .d     (shared_pad_in),
    .q     (shared_in_s)
  );

  bst_sync3 #(.W(NP)) u_sync_pins (
    .clk   (clk_sys),
    .rst_n (rst_sys_n),
    .d     (pin_in),
    .q     (pin_in_s)
  );

  // Configuration is caught after reset release, never by the reset itself
  always_ff @(posedge clk_sys or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      cfg_user_io <= 1'b0;
      test_active <= 1'b1;
    end else begin
      cfg_user_io <= cfg_pins_user_io;
      test_active <= !cfg_user_io || reclaim_s; // R02 R03 R05
    end
  end

  // Shared pads: user function only when the test port is off
  always_ff @(posedge clk_sys or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      shared_pad_out <= '0;
      shared_pad_oe  <= '0;
      user_in        <= '0;
    end else begin
      shared_pad_out <= user_out;
      if (test_active) begin
        shared_pad_oe <= '0; // R07
        user_in       <= '0; // R07
      end else if (ir_sys == bst_pkg::IR_HIGHZ) begin
        shared_pad_oe <= '0; // R13
        user_in       <= shared_in_s;
      end else begin
        shared_pad_oe <= user_oe; // R03
        user_in       <= shared_in_s;
      end
    end
  end

  bst_sync3 #(.W(1)) u_sync_tog (
    .clk   (clk_sys),
    .rst_n (rst_sys_n),
    .d     (upd_tog),
    .q     (upd_tog_s)
  );

  // Update words are stable for many system cycles after each toggle
  always_ff @(posedge clk_sys or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      upd_tog_seen <= 1'b0;
      ir_sys       <= bst_pkg::IR_RESET;
      bs_sys       <= '0;
    end else begin
      upd_tog_seen <= upd_tog_s;
      if (!test_active) begin
        ir_sys <= bst_pkg::IR_RESET; // R03
      end else if (upd_tog_s != upd_tog_seen) begin
        ir_sys <= ir;
        bs_sys <= bs_upd;
      end
    end
  end

  // System pins and core inputs
  always_ff @(posedge clk_sys or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      pin_out <= '0;
      pin_oe  <= '0;
      core_in <= '0;
    end else begin
      case (ir_sys)
        bst_pkg::IR_EXTEST, bst_pkg::IR_INTEST: begin
          pin_out <= bs_cells(bs_sys, bst_pkg::BS_DATA_OFS); // R09
          pin_oe  <= bs_cells(bs_sys, bst_pkg::BS_EN_OFS); // R09
        end
        bst_pkg::IR_HIGHZ: begin
          pin_out <= core_out;
          pin_oe  <= '0; // R13
        end
        default: begin
          pin_out <= core_out; // R10
          pin_oe  <= core_oe;
        end
      endcase
      if (ir_sys == bst_pkg::IR_INTEST) begin
        core_in <= bs_cells(bs_sys, bst_pkg::BS_DATA_OFS); // R14
      end else begin
        core_in <= pin_in_s;
      end
    end
  end

  // Snapshot offered to the capture cells
  always_ff @(posedge clk_sys or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      snap_sys <= '0;
    end else begin
      for (int i = 0; i < NP; i++) begin
        snap_sys[2*i+bst_pkg::BS_DATA_OFS] <= pin_in_s[i]; // R08
        snap_sys[2*i+bst_pkg::BS_EN_OFS]   <= core_oe[i];
      end
    end
  end

  // ---------------- Test clock domain ----------------
  // Leaving test mode resets this side at once, even with the test clock stopped
  assign rst_tck_src = rst_sys_n && test_active; // R06

  // Release of the test reset follows the test clock
  always_ff @(posedge tck or negedge rst_tck_src) begin
    if (!rst_tck_src) begin
      rst_tck_q1 <= 1'b0; // R01
      rst_tck_n  <= 1'b0;
    end else begin
      rst_tck_q1 <= 1'b1;
      rst_tck_n  <= rst_tck_q1;
    end
  end

  bst_sync3 #(.W(1)) u_sync_active (
    .clk   (tck),
    .rst_n (rst_tck_n),
    .d     (test_active),
    .q     (active_tck)
  );

  // Snapshot bits may settle a few test clocks apart
  bst_sync3 #(.W(BW)) u_sync_snap (
    .clk   (tck),
    .rst_n (rst_tck_n),
    .d     (snap_sys),
    .q     (snap_tck)
  );

  bst_tap_fsm u_tap (
    .tck   (tck),
    .rst_n (rst_tck_n),
    .hold  (!active_tck), // R06
    .tms   (tms),
    .state (state)
  );

  // Instruction shifter and active instruction
  always_ff @(posedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      ir_sr <= bst_pkg::IR_CAPTURE;
      ir    <= bst_pkg::IR_RESET;
    end else begin
      case (state)
        bst_pkg::TAP_RESET:    ir    <= bst_pkg::IR_RESET;
        bst_pkg::TAP_CAP_IR:   ir_sr <= bst_pkg::IR_CAPTURE;
        bst_pkg::TAP_SHIFT_IR: ir_sr <= {tdi, ir_sr[IW-1:1]}; // R15 R11
        bst_pkg::TAP_UPD_IR:   ir    <= ir_sr; // R19
        default:               ir    <= ir;
      endcase
    end
  end

  // Tells the system side a new instruction or update word is ready
  always_ff @(posedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      upd_tog <= 1'b0;
    end else if (state == bst_pkg::TAP_UPD_IR || state == bst_pkg::TAP_UPD_DR ||
                 (state == bst_pkg::TAP_RESET && ir != bst_pkg::IR_RESET)) begin
      upd_tog <= !upd_tog;
    end
  end

  // Bypass stage, also taken by undefined codes
  always_ff @(posedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      bypass_sr <= 1'b0;
    end else if (state == bst_pkg::TAP_CAP_DR) begin
      bypass_sr <= 1'b0; // R10
    end else if (state == bst_pkg::TAP_SHIFT_DR) begin
      bypass_sr <= tdi; // R10 R13 R20
    end
  end

  // Identification shifter
  always_ff @(posedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      id_sr <= bst_pkg::ID_VALUE;
    end else if (ir == bst_pkg::IR_IDCODE) begin
      if (state == bst_pkg::TAP_CAP_DR) begin
        id_sr <= bst_pkg::ID_VALUE; // R12
      end else if (state == bst_pkg::TAP_SHIFT_DR) begin
        id_sr <= {tdi, id_sr[bst_pkg::ID_W-1:1]}; // R12
      end
    end
  end

  // Boundary shifter and its latched parallel outputs
  always_ff @(posedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      bs_sr  <= '0;
      bs_upd <= '0;
    end else if (is_bs_reg(ir)) begin
      case (state)
        bst_pkg::TAP_CAP_DR:   bs_sr  <= snap_tck; // R08
        bst_pkg::TAP_SHIFT_DR: bs_sr  <= {tdi, bs_sr[BW-1:1]}; // R08 R15
        bst_pkg::TAP_UPD_DR:   bs_upd <= bs_sr; // R08 R14
        default:               bs_sr  <= bs_sr;
      endcase
    end
  end

  always_comb begin
    if (is_bs_reg(ir)) begin
      dr_bit = bs_sr[0];
    end else if (ir == bst_pkg::IR_IDCODE) begin
      dr_bit = id_sr[0];
    end else begin
      dr_bit = bypass_sr; // R20
    end
  end

  // Serial output moves only on the falling edge
  always_ff @(negedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      if (state == bst_pkg::TAP_SHIFT_IR) begin
        tdo <= ir_sr[0]; // R16
      end else if (state == bst_pkg::TAP_SHIFT_DR) begin
        tdo <= dr_bit; // R16
      end
      tdo_oe <= active_tck &&
                (state == bst_pkg::TAP_SHIFT_IR || state == bst_pkg::TAP_SHIFT_DR); // R17
    end
  end

endmodule

/* File: verification/bst_chk_sva.sv */
// Assertion checker for the boundary-scan test port
module bst_chk (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       tck,
  input wire logic       tms,
  input wire logic       tdo,
  input wire logic       tdo_oe,
  input wire logic       port_reclaim,
  input wire logic       cfg_pins_user_io,
  input wire logic [3:0] shared_pad_out,
  input wire logic [3:0] shared_pad_oe,
  input wire logic [3:0] user_out,
  input wire logic [3:0] user_oe,
  input wire logic [3:0] user_in,
  input wire logic [7:0] pin_oe
);
  logic [5:0] usr_cnt;
  logic [5:0] tst_cnt;

  // Run lengths of each pin mode, so the sync latency is skipped
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) usr_cnt <= 6'h00;
    else if (!cfg_pins_user_io || port_reclaim) usr_cnt <= 6'h00;
    else if (usr_cnt != 6'h3F) usr_cnt <= usr_cnt + 6'h01;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) tst_cnt <= 6'h00;
    else if (cfg_pins_user_io && !port_reclaim) tst_cnt <= 6'h00;
    else if (tst_cnt != 6'h3F) tst_cnt <= tst_cnt + 6'h01;
  end

  sequence s_shift_open;
    !tdo_oe ##1 tdo_oe;
  endsequence

  sequence s_shift_close;
    tdo_oe ##1 !tdo_oe;
  endsequence

  reset_release_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(nrst) |-> pin_oe == 8'h00 && shared_pad_oe == 4'h0 && !tdo_oe)
    else $error("outputs active right after reset");
  tdo_edge_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !$past(tck) |-> $stable(tdo) && $stable(tdo_oe))
    else $error("serial output moved without a falling test clock");
  shift_entry_a: assert property (@(posedge tck) disable iff (!nrst)
    s_shift_open |-> !$past(tms))
    else $error("serial output enabled outside a shift");
  shift_exit_a: assert property (@(posedge tck) disable iff (!nrst)
    s_shift_close |-> $past(tms))
    else $error("serial output released inside a shift");
  user_refuse_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    usr_cnt > 6'h28 |-> !tdo_oe)
    else $error("test port answered in user mode");
  user_resume_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    usr_cnt > 6'h28 |-> shared_pad_oe == $past(user_oe) && shared_pad_out == $past(user_out))
    else $error("shared pins not following user logic");
  test_pins_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    tst_cnt > 6'h0C |-> user_in == 4'h0)
    else $error("shared pins reach user logic in test mode");
  buried_logic_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    tst_cnt > 6'h0C && user_oe != 4'h0 |-> shared_pad_oe == 4'h0)
    else $error("buried macrocell drives a shared pin");
endmodule

/* File: verification/bst_ctrl_model.sv */
// Behavioural serial test controller for the link side
module bst_ctrl_model (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo_pad
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // One link cycle; the clock stands still between frames
  task automatic cyc(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #80 tck = 1'b1;
    q = tdo_pad;
    #80 tck = 1'b0;
  endtask

  // Idle to shift, n bits LSB first, update, back to idle
  task automatic scan(input bit ir, input logic [31:0] din, input int n,
                      output logic [31:0] dout);
    logic q;
    dout = 32'h0;
    #7;
    cyc(1'b1, ~tdi, q);
    if (ir) cyc(1'b1, ~tdi, q);
    cyc(1'b0, ~tdi, q);
    cyc(1'b0, ~tdi, q);
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1, din[i], q);
      dout[i] = q;
    end
    cyc(1'b1, ~tdi, q);
    cyc(1'b0, ~tdi, q);
    tms = 1'b1;
  endtask

  task automatic reset_tap();
    logic q;
    #7;
    // Extra ones cover the test clock reset release and the mode sync
    repeat (8) cyc(1'b1, 1'b1, q);
    cyc(1'b0, 1'b1, q);
    tms = 1'b1;
  endtask
endmodule

/* File: verification/tb_top.sv */
// Self-checking testbench for the boundary-scan test port
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, nrst, tck, tms, tdi, tdo, tdo_oe, tdo_pad;
  logic        port_reclaim, cfg_pins_user_io;
  logic [3:0]  shared_pad_out, shared_pad_oe, user_out, user_oe, user_in;
  logic [7:0]  pin_in, pin_out, pin_oe, core_out, core_oe, core_in;
  logic [31:0] rd;
  int          n_errors, compares;

  // Pull-up holds the pad when nobody drives it
  assign tdo_pad = tdo_oe ? tdo : (shared_pad_oe[3] ? shared_pad_out[3] : 1'b1);

  bst_test_port dut (.clk_sys, .nrst, .tck, .tms, .tdi, .tdo, .tdo_oe, .port_reclaim,
    .cfg_pins_user_io, .shared_pad_in({tdo_pad, tdi, tms, tck}), .shared_pad_out,
    .shared_pad_oe, .user_out, .user_oe, .user_in, .pin_in, .pin_out, .pin_oe,
    .core_out, .core_oe, .core_in);

  bst_ctrl_model ctl (.tck, .tms, .tdi, .tdo_pad);

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic test_done();
    if (n_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic ir(input logic [4:0] c);
    logic [31:0] q;
    @(posedge clk_sys);
    ctl.scan(1'b1, {27'h0, c}, 5, q);
    `CHK(q[4:0], bst_pkg::IR_CAPTURE)
    repeat (10) @(posedge clk_sys);
  endtask

  task automatic dr(input logic [31:0] d, input int n);
    @(posedge clk_sys);
    ctl.scan(1'b0, d, n, rd);
    repeat (10) @(posedge clk_sys);
  endtask

  task automatic rst_tap();
    @(posedge clk_sys);
    ctl.reset_tap();
    repeat (10) @(posedge clk_sys);
  endtask

  function automatic logic [7:0] cells(input logic [15:0] w, input int o);
    for (int i = 0; i < 8; i++) cells[i] = w[2*i+o];
  endfunction

  task automatic t_idcode();
    dr(32'h0, 32);
    `CHK(rd, bst_pkg::ID_VALUE)
  endtask

  task automatic t_bypass();
    logic [4:0] codes [4] = '{bst_pkg::IR_BYPASS, 5'h09, 5'h0C, 5'h1A};
    foreach (codes[k]) begin
      ir(codes[k]);
      dr(32'h0000_00B5, 8);
      `CHK(rd[7:0], 8'h6A)
      `CHK(pin_out, core_out)
      `CHK(pin_oe, core_oe)
    end
  endtask

  task automatic t_highz();
    ir(bst_pkg::IR_HIGHZ);
    `CHK(pin_oe, 8'h00)
    dr(32'h0000_00B5, 8);
    `CHK(rd[7:0], 8'h6A)
  endtask

  task automatic t_boundary();
    logic [15:0] cap;
    logic [7:0]  pv = 8'hC3;
    logic [7:0]  ov = 8'hA6;
    @(posedge clk_sys);
    pin_in  <= pv;
    core_oe <= ov;
    for (int i = 0; i < 8; i++) begin
      cap[2*i]   = pv[i];
      cap[2*i+1] = ov[i];
    end
    ir(bst_pkg::IR_SAMPLE);
    dr(32'h0000_9C63, 16);
    `CHK(rd[15:0], cap)
    ir(bst_pkg::IR_EXTEST);
    `CHK(pin_out, cells(16'h9C63, bst_pkg::BS_DATA_OFS))
    `CHK(pin_oe, cells(16'h9C63, bst_pkg::BS_EN_OFS))
    ir(bst_pkg::IR_INTEST);
    `CHK(core_in, cells(16'h9C63, bst_pkg::BS_DATA_OFS))
    rst_tap();
    `CHK(core_in, pv)
  endtask

  task automatic t_user();
    @(posedge clk_sys);
    cfg_pins_user_io <= 1'b1;
    user_out         <= 4'h9;
    user_oe          <= 4'h6;
    repeat (60) @(posedge clk_sys);
    dr(32'h0, 32);
    `CHK(rd, 32'hFFFF_FFFF)
    port_reclaim <= 1'b1;
    repeat (20) @(posedge clk_sys);
    rst_tap();
    dr(32'h0, 32);
    `CHK(rd, bst_pkg::ID_VALUE)
    `CHK(shared_pad_oe, 4'h0)
    port_reclaim <= 1'b0;
    repeat (60) @(posedge clk_sys);
    `CHK(shared_pad_oe, 4'h6)
    `CHK(shared_pad_out, 4'h9)
    `CHK(user_in, {1'b1, tdi, tms, tck})
  endtask

  initial begin
    nrst             = 1'b0;
    port_reclaim     = 1'b0;
    cfg_pins_user_io = 1'b0;
    user_out         = 4'h0;
    user_oe          = 4'hF;
    pin_in           = 8'h00;
    core_out         = 8'h5A;
    core_oe          = 8'hFF;
    n_errors         = 0;
    compares         = 0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst_tap();
    t_idcode();
    t_bypass();
    t_highz();
    t_boundary();
    t_user();
    test_done();
  end

  // Whole run needs well under half of this
  initial begin
    #2000000;
    n_errors++;
    test_done();
  end
endmodule

bind bst_test_port bst_chk u_chk (.clk_sys, .nrst, .tck, .tms, .tdo, .tdo_oe, .port_reclaim,
  .cfg_pins_user_io, .shared_pad_out, .shared_pad_oe, .user_out, .user_oe, .user_in,
  .pin_oe);
